// ==== hw/freq_link_pkg.sv ====
// Package with register map, field codes and carrier structs for the offset and logic link block.
package freq_link_pkg;

  // Frequencies are in units of 0.1 Hz, 16 bits wide.
  localparam int FREQ_W = 16;
  localparam logic [15:0] FREQ_MAX_OFFSET = 16'h0fa0;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] END_FREQ_RESET = 16'h01f4;

  // Word addresses of the register map (byte address divided by four).
  localparam logic [3:0] ADDR_OFFSET_VALUE = 4'h0;
  localparam logic [3:0] ADDR_OFFSET_SIGN = 4'h1;
  localparam logic [3:0] ADDR_END_FREQ = 4'h2;
  localparam logic [3:0] ADDR_REF_SELECT = 4'h3;
  localparam logic [3:0] ADDR_INPUT_FUNC = 4'h4;
  localparam logic [3:0] ADDR_LINK_SELECT = 4'h5;
  localparam logic [3:0] ADDR_OUTPUT_ASSIGN = 4'h6;
  localparam logic [3:0] ADDR_FREQ_STATUS = 4'h7;
  localparam logic [3:0] ADDR_LINK_STATUS = 4'h8;

  // Field codes.
  localparam logic [7:0] FUNC_OFFSET_APPLY = 8'h32;
  localparam logic [1:0] SIGN_ADD = 2'h0;
  localparam logic [1:0] SIGN_SUB = 2'h1;
  localparam logic [1:0] OP_AND = 2'h0;
  localparam logic [1:0] OP_OR = 2'h1;
  localparam logic [1:0] OP_XOR = 2'h2;
  localparam logic [3:0] LINK_A_RESET = 4'h0;
  localparam logic [3:0] LINK_B_RESET = 4'h1;
  localparam logic [7:0] OUT_LINK_CODE = 8'h3f;
  localparam int NUM_INPUTS = 5;
  localparam int NUM_OUTPUTS = 3;
  localparam int NUM_REFS = 4;
  localparam int NUM_STATUS = 11;

  // Status inputs gathered from the rest of the drive.
  typedef struct packed {
    logic running;
    logic freq_reached_flag;
    logic ramp_up;
    logic ramp_down;
    logic [15:0] output_freq;
    logic [15:0] accel_freq_threshold;
    logic [15:0] decel_freq_threshold;
    logic overcurrent;
    logic pid_deviation_over;
    logic alarm_flag;
    logic voltage_ref_low;
    logic current_ref_under_4ma;
    logic actual_value_limit_flag;
    logic comm_watchdog_flag;
    logic comm_overload_flag;
  } drive_status_s;

  // Speed command leaving the offset stage.
  typedef struct packed {
    logic reverse_rotation;
    logic [15:0] freq;
  } speed_cmd_s;

endpackage : freq_link_pkg

// ==== hw/logic_link_unit.sv ====
// Selects two status signals and combines them by AND, OR or XOR.
`timescale 1ns/1ps
module logic_link_unit (
  input wire logic [10:0] status_vec,
  input wire logic [3:0] link_input_a_select,
  input wire logic [3:0] link_input_b_select,
  input wire logic [1:0] link_operation_select,
  output logic link_result
);

  // Codes above 10 pick a constant low; the unused code 09 picks status_vec[9], which the top ties low.
  function automatic logic pick(input logic [10:0] vec, input logic [3:0] code);
    pick = (code < 4'hb) ? vec[code] : 1'b0;
  endfunction : pick

  logic sig_a;
  logic sig_b;

  // Combine the two picked signals per the truth table.
  always_comb
  begin
    sig_a = pick(status_vec, link_input_a_select);
    sig_b = pick(status_vec, link_input_b_select);
    case (link_operation_select)
      freq_link_pkg::OP_AND: link_result = sig_a & sig_b;
      freq_link_pkg::OP_OR: link_result = sig_a | sig_b;
      freq_link_pkg::OP_XOR: link_result = sig_a ^ sig_b;
      default: link_result = 1'b0;
    endcase
  end

endmodule : logic_link_unit

// ==== hw/freq_offset_and_logic_link.sv ====
// Frequency offset stage and logic link with an Avalon-MM register slave.
// Contract
// - Input with function code 50 applies offset.
// - Offset applied only while that input active.
// - Stored offset up to 400 Hz, reset zero.
// - Sign code 00 adds, 01 subtracts.
// - Added result clamped to end frequency.
// - Negative difference reverses rotation, magnitude output.
// - Link follows AND, OR, XOR truth table.
// - Operation code 00 AND, 01 OR, 02 XOR.
// - Link inputs picked by code; defaults 00, 01.
// - Code 02 frequency above ramp threshold.
// - Code 03 motor current over overload threshold.
// - Code 04 PID deviation; code 05 alarm.
// - Code 06 reference loss warning.
// - Codes 07, 08, 10: limits, watchdog, comm.
// - Link result routable to three outputs.
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module freq_offset_and_logic_link (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [4:0] digital_in,
  input wire logic [63:0] reference_sources,
  input wire logic [7:0] other_output_sources,
  input wire freq_link_pkg::drive_status_s drive_status,
  output freq_link_pkg::speed_cmd_s speed_cmd,
  output logic [2:0] digital_out
);

  // Configuration registers.
  logic [15:0] offset_value_param;
  logic [1:0] offset_sign_param;
  logic [15:0] end_frequency_param;
  logic [1:0] reference_source_select;
  logic [39:0] input_function_select;
  logic [3:0] link_input_a_select;
  logic [3:0] link_input_b_select;
  logic [1:0] link_operation_select;
  logic [23:0] output_assign;
  logic [15:0] next_offset_value_param;
  logic [1:0] next_offset_sign_param;
  logic [15:0] next_end_frequency_param;
  logic [1:0] next_reference_source_select;
  logic [39:0] next_input_function_select;
  logic [3:0] next_link_input_a_select;
  logic [3:0] next_link_input_b_select;
  logic [1:0] next_link_operation_select;
  logic [23:0] next_output_assign;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic ack_phase;
  logic next_ack_phase;

  // Merge the enabled byte lanes of a write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        merge[i*8 +: 8] = wd[i*8 +: 8];
  endfunction : merge

  // Datapath state.
  freq_link_pkg::speed_cmd_s next_speed_cmd;
  logic [2:0] next_digital_out;
  logic [15:0] base_ref;
  logic [15:0] next_base_ref;
  logic apply;
  logic next_apply;
  logic [10:0] status_vec;
  logic link_result;
  logic [31:0] wr_word;
  logic [31:0] rd_word;

  // Status vector, bit index equals the selection code; bit 9 is unused.
  always_comb
  begin
    status_vec[0] = drive_status.running;
    status_vec[1] = drive_status.freq_reached_flag;
    status_vec[2] = (drive_status.ramp_up && drive_status.output_freq > drive_status.accel_freq_threshold)
      || (drive_status.ramp_down && drive_status.output_freq > drive_status.decel_freq_threshold);
    status_vec[3] = drive_status.overcurrent;
    status_vec[4] = drive_status.pid_deviation_over;
    status_vec[5] = drive_status.alarm_flag;
    status_vec[6] = drive_status.voltage_ref_low | drive_status.current_ref_under_4ma;
    status_vec[7] = drive_status.actual_value_limit_flag;
    status_vec[8] = drive_status.comm_watchdog_flag;
    status_vec[9] = 1'b0;
    status_vec[10] = drive_status.comm_overload_flag;
  end

  logic_link_unit link_inst (
    .status_vec(status_vec),
    .link_input_a_select(link_input_a_select),
    .link_input_b_select(link_input_b_select),
    .link_operation_select(link_operation_select),
    .link_result(link_result)
  );

  // Read mux of the register map; unmapped words read zero.
  always_comb
  begin
    case (avs_address)
      freq_link_pkg::ADDR_OFFSET_VALUE: rd_word = {16'h0000, offset_value_param};
      freq_link_pkg::ADDR_OFFSET_SIGN: rd_word = {30'h00000000, offset_sign_param};
      freq_link_pkg::ADDR_END_FREQ: rd_word = {16'h0000, end_frequency_param};
      freq_link_pkg::ADDR_REF_SELECT: rd_word = {30'h00000000, reference_source_select};
      freq_link_pkg::ADDR_INPUT_FUNC: rd_word = input_function_select[31:0];
      freq_link_pkg::ADDR_LINK_SELECT: rd_word = {8'h00, input_function_select[39:32], 6'h00,
                                                  link_operation_select, link_input_b_select, link_input_a_select};
      freq_link_pkg::ADDR_OUTPUT_ASSIGN: rd_word = {8'h00, output_assign};
      freq_link_pkg::ADDR_FREQ_STATUS: rd_word = {14'h0000, apply, speed_cmd.reverse_rotation, speed_cmd.freq};
      freq_link_pkg::ADDR_LINK_STATUS: rd_word = {17'h00000, link_result, 3'h0, status_vec};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Register writes and the one-wait-state handshake: waitrequest drops one cycle after the request.
  always_comb
  begin
    next_offset_value_param = offset_value_param;
    next_offset_sign_param = offset_sign_param;
    next_end_frequency_param = end_frequency_param;
    next_reference_source_select = reference_source_select;
    next_input_function_select = input_function_select;
    next_link_input_a_select = link_input_a_select;
    next_link_input_b_select = link_input_b_select;
    next_link_operation_select = link_operation_select;
    next_output_assign = output_assign;
    next_readdata = avs_readdata;
    wr_word = merge(rd_word, avs_writedata, avs_byteenable);
    next_ack_phase = (avs_read | avs_write) & ~ack_phase;
    next_waitrequest = ~next_ack_phase;
    if (avs_read && !ack_phase)
      next_readdata = rd_word;
    if (avs_write && ack_phase)
    begin
      case (avs_address)
        freq_link_pkg::ADDR_OFFSET_VALUE:
          // Values above 400 Hz saturate so the stored offset stays in range.
          next_offset_value_param = (wr_word[15:0] > freq_link_pkg::FREQ_MAX_OFFSET)
                                  ? freq_link_pkg::FREQ_MAX_OFFSET : wr_word[15:0];
        freq_link_pkg::ADDR_OFFSET_SIGN: next_offset_sign_param = wr_word[1:0];
        freq_link_pkg::ADDR_END_FREQ: next_end_frequency_param = wr_word[15:0];
        freq_link_pkg::ADDR_REF_SELECT: next_reference_source_select = wr_word[1:0];
        freq_link_pkg::ADDR_INPUT_FUNC: next_input_function_select[31:0] = wr_word;
        freq_link_pkg::ADDR_LINK_SELECT:
        begin
          next_link_input_a_select = wr_word[3:0];
          next_link_input_b_select = wr_word[7:4];
          next_link_operation_select = wr_word[9:8];
          next_input_function_select[39:32] = wr_word[23:16];
        end
        freq_link_pkg::ADDR_OUTPUT_ASSIGN: next_output_assign = wr_word[23:0];
        default: next_ack_phase = 1'b0;
      endcase
      next_ack_phase = 1'b0;
    end
  end

  // Offset datapath: reference pick, apply detection, add with clamp or subtract with reversal.
  always_comb
  begin
    next_base_ref = reference_sources[reference_source_select*16 +: 16];
    next_apply = 1'b0;
    for (int i = 0; i < freq_link_pkg::NUM_INPUTS; i++)
      if (input_function_select[i*8 +: 8] == freq_link_pkg::FUNC_OFFSET_APPLY && digital_in[i])
        next_apply = 1'b1;
    next_speed_cmd.reverse_rotation = 1'b0;
    next_speed_cmd.freq = base_ref;
    if (apply)
    begin
      if (offset_sign_param == freq_link_pkg::SIGN_SUB)
      begin
        if (offset_value_param > base_ref)
        begin
          next_speed_cmd.reverse_rotation = 1'b1;
          next_speed_cmd.freq = offset_value_param - base_ref;
        end
        else
          next_speed_cmd.freq = base_ref - offset_value_param;
      end
      else
      begin
        // A 17-bit sum keeps the carry so the clamp cannot be fooled by wrap-around.
        if ({1'b0, base_ref} + {1'b0, offset_value_param} > {1'b0, end_frequency_param})
          next_speed_cmd.freq = end_frequency_param;
        else
          next_speed_cmd.freq = base_ref + offset_value_param;
      end
    end
  end

  // Output routing: each output shows the link result when assigned its code.
  generate
    for (genvar k = 0; k < freq_link_pkg::NUM_OUTPUTS; k++)
    begin : g_out
      assign next_digital_out[k] = (output_assign[k*8 +: 8] == freq_link_pkg::OUT_LINK_CODE)
                                 ? link_result : other_output_sources[k];
    end
  endgenerate

  // State registers.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      offset_value_param <= freq_link_pkg::OFFSET_RESET;
      offset_sign_param <= freq_link_pkg::SIGN_ADD;
      end_frequency_param <= freq_link_pkg::END_FREQ_RESET;
      reference_source_select <= 2'h0;
      input_function_select <= 40'h0000000000;
      link_input_a_select <= freq_link_pkg::LINK_A_RESET;
      link_input_b_select <= freq_link_pkg::LINK_B_RESET;
      link_operation_select <= freq_link_pkg::OP_AND;
      output_assign <= 24'h000000;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      ack_phase <= 1'b0;
      base_ref <= 16'h0000;
      apply <= 1'b0;
      speed_cmd <= '0;
      digital_out <= 3'h0;
    end
    else
    begin
      offset_value_param <= next_offset_value_param;
      offset_sign_param <= next_offset_sign_param;
      end_frequency_param <= next_end_frequency_param;
      reference_source_select <= next_reference_source_select;
      input_function_select <= next_input_function_select;
      link_input_a_select <= next_link_input_a_select;
      link_input_b_select <= next_link_input_b_select;
      link_operation_select <= next_link_operation_select;
      output_assign <= next_output_assign;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      ack_phase <= next_ack_phase;
      base_ref <= next_base_ref;
      apply <= next_apply;
      speed_cmd <= next_speed_cmd;
      digital_out <= next_digital_out;
    end
  end

endmodule : freq_offset_and_logic_link

// ==== verif/freq_link_props.sv ====
// Checker for the bus handshake, the offset path and the status readback.
`timescale 1ns/1ps
module freq_link_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [4:0] digital_in,
  input wire logic [63:0] reference_sources,
  input wire freq_link_pkg::drive_status_s drive_status,
  input wire freq_link_pkg::speed_cmd_s speed_cmd,
  input wire logic [2:0] digital_out
);
  logic rd_go;
  logic [10:0] flags;
  // Flags copied straight into the status vector; code 02 is a compare, so its slot stays masked.
  assign rd_go = avs_read && avs_waitrequest;
  assign flags = {drive_status.comm_overload_flag, 1'b0, drive_status.comm_watchdog_flag,
    drive_status.actual_value_limit_flag, drive_status.voltage_ref_low | drive_status.current_ref_under_4ma,
    drive_status.alarm_flag, drive_status.pid_deviation_over, drive_status.overcurrent, 1'b0,
    drive_status.freq_reached_flag, drive_status.running};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("Answer held too long.");
  a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request not answered.");
  a_idle_quiet: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("Answer without a request.");
  a_offset_capped: assert property (rd_go && avs_address == 4'h0 |=> avs_readdata <= 32'h0fa0)
    else $error("Stored offset above its ceiling.");
  a_unmapped_zero: assert property (rd_go && avs_address > 4'h8 |=> avs_readdata == 32'h0)
    else $error("Unmapped read not zero.");
  a_apply_clear: assert property ((digital_in == 5'h0) [*3] ##0 (rd_go && avs_address == 4'h7)
    |=> !avs_readdata[17]) else $error("Offset applied with all inputs low.");
  a_plain_ref: assert property ((digital_in == 5'h0 && reference_sources == {4{reference_sources[15:0]}}
    && $stable(reference_sources)) [*3] |-> speed_cmd == {1'b0, reference_sources[15:0]})
    else $error("Idle command differs from the reference.");
  a_status_copy: assert property ($stable(flags) [*2]
    ##0 (rd_go && avs_address == 4'h8)
    |=> (avs_readdata[10:0] & 11'h7fb) == $past(flags)) else $error("Status vector differs from the flags.");
  a_reg8_reserved: assert property (rd_go && avs_address == 4'h8 |=> avs_readdata[31:15] == 17'h0
    && avs_readdata[13:11] == 3'h0) else $error("Unused status bits set.");
  a_reverse_nonzero: assert property (speed_cmd.reverse_rotation |-> speed_cmd.freq != 16'h0)
    else $error("Reverse with zero magnitude.");
  // Main scenarios seen at least once.
  c_write: cover property (avs_write && !avs_waitrequest);
  c_reverse: cover property (speed_cmd.reverse_rotation);
  c_out_moves: cover property ($changed(digital_out));
endmodule : freq_link_props
bind freq_offset_and_logic_link freq_link_props props (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .digital_in, .reference_sources, .drive_status, .speed_cmd, .digital_out);

// ==== verif/motor_path_model.sv ====
// Far-side model: the motor command path and the output loads, latching what the block sends.
`timescale 1ns/1ps
module motor_path_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire freq_link_pkg::speed_cmd_s speed_cmd,
  input wire logic [2:0] digital_out,
  output freq_link_pkg::speed_cmd_s motor_cmd,
  output logic [2:0] loads
);
  freq_link_pkg::speed_cmd_s next_motor_cmd;
  logic [2:0] next_loads;
  // The drive stage takes each command one cycle late, so the bench sees what really reached the motor.
  always_comb
  begin
    next_motor_cmd = speed_cmd;
    next_loads = digital_out;
  end
  // Registers only.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      motor_cmd <= '0;
      loads <= 3'h0;
    end
    else
    begin
      motor_cmd <= next_motor_cmd;
      loads <= next_loads;
    end
  end
endmodule : motor_path_model

// ==== verif/freq_offset_and_logic_link_tb.sv ====
// Random and corner-case bench for the offset stage and the logic link.
`timescale 1ns/1ps
module freq_offset_and_logic_link_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read, avs_write, avs_waitrequest, on, sub, lk;
  logic [31:0] avs_writedata, avs_readdata, rd, seed = 32'h6cbcd258;
  logic [3:0] avs_address, avs_byteenable, a, b;
  logic [4:0] digital_in;
  logic [63:0] reference_sources, r64;
  logic [7:0] other_output_sources;
  logic [2:0] digital_out, loads;
  logic [15:0] base, off, endf;
  logic [10:0] st;
  logic [16:0] es;
  logic [1:0] op;
  int k, sel;
  int n_errors = 0;
  int comparisons = 0;
  logic [35:0] rv [4] = '{{4'h0, 32'h0}, {4'h1, 32'h0}, {4'h2, 32'h1f4}, {4'h5, 32'h10}};
  freq_link_pkg::drive_status_s drive_status;
  freq_link_pkg::speed_cmd_s speed_cmd, motor_cmd;
  freq_offset_and_logic_link DUT (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .digital_in, .reference_sources, .other_output_sources,
    .drive_status, .speed_cmd, .digital_out);
  motor_path_model model (.sys_clk, .rst, .speed_cmd, .digital_out, .motor_cmd, .loads);
  // Free-running system clock, 40 ns period.
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // Offset only acts while applied; only a sum is clamped, a negative difference turns the motor round.
  function automatic logic [16:0] exp_speed(input logic [15:0] bs, of, ef, input logic sb, ap);
    logic [16:0] s;
    s = {1'b0, bs} + {1'b0, of};
    if (!ap)
      return {1'b0, bs};
    if (sb)
      return (of > bs) ? {1'b1, of - bs} : {1'b0, bs - of};
    return (s > {1'b0, ef}) ? {1'b0, ef} : s;
  endfunction : exp_speed
  function automatic logic [10:0] exp_status(input freq_link_pkg::drive_status_s d);
    logic fa;
    fa = (d.ramp_up && d.output_freq > d.accel_freq_threshold)
      || (d.ramp_down && d.output_freq > d.decel_freq_threshold);
    return {d.comm_overload_flag, 1'b0, d.comm_watchdog_flag, d.actual_value_limit_flag, d.voltage_ref_low
      | d.current_ref_under_4ma, d.alarm_flag, d.pid_deviation_over, d.overcurrent, fa, d.freq_reached_flag, d.running};
  endfunction : exp_status
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer; the request stands until a rising edge sees waitrequest low, and read data is taken there.
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d.", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Cuts a hang short; the full run needs about 1400 cycles.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
  // Main sequence: reset values, ceilings, offset arithmetic, then the logic link.
  initial
  begin
    {avs_read, avs_write, avs_address, avs_writedata, digital_in, other_output_sources} = 51'h0;
    avs_byteenable = 4'hf;
    reference_sources = 64'h0;
    drive_status = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rv[i])
    begin
      bus(1'b0, rv[i][35:32], 32'h0);
      chk(rd, rv[i][31:0]);
    end
    bus(1'b1, 4'h0, 32'hffff);
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0fa0);
    bus(1'b1, 4'hc, 32'hffffffff);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h0);
    @(posedge sys_clk);
    reference_sources <= {4{16'h0123}};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({15'h0, speed_cmd}, 32'h123);
    bus(1'b0, 4'h7, 32'h0);
    chk(rd, 32'h123);
    for (int i = 0; i < 40; i++)
    begin
      k = (i < 2) ? 0 : xs() % 5;
      sel = xs() % 4;
      base = (i < 2) ? 16'h00c8 : 16'(xs() % 32'h8000);
      off = (i < 2) ? 16'h00c8 : 16'(xs() % 32'h0fa1);
      endf = (i < 2) ? 16'h0190 : 16'(xs()) | 16'h8000;
      sub = i[0];
      on = (i < 2) || (xs() % 2 == 1);
      bus(1'b1, 4'h0, {16'h0, off});
      bus(1'b1, 4'h1, {31'h0, sub});
      bus(1'b1, 4'h2, {16'h0, endf});
      bus(1'b1, 4'h3, sel);
      bus(1'b1, 4'h4, (k < 4) ? 32'h32 << (8 * k) : 32'h0);
      bus(1'b1, 4'h5, (k == 4) ? 32'h320010 : 32'h10);
      r64 = {xs(), xs()};
      r64[sel * 16 +: 16] = base;
      @(posedge sys_clk);
      reference_sources <= r64;
      digital_in <= (5'(xs()) & ~(5'h1 << k)) | (5'(on) << k);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      es = exp_speed(base, off, endf, sub, on);
      chk({15'h0, motor_cmd}, {15'h0, es});
      bus(1'b0, 4'h7, 32'h0);
      chk(rd, {14'h0, on, es});
    end
    for (int i = 0; i < 33; i++)
    begin
      op = 2'(i % 3);
      a = 4'(xs() % 11);
      b = 4'(xs() % 11);
      bus(1'b1, 4'h5, {22'h0, op, b, a});
      bus(1'b1, 4'h6, i[0] ? 32'h3f3f3f : 32'h0);
      r64 = {xs(), xs()};
      @(posedge sys_clk);
      drive_status <= r64[59:0];
      other_output_sources <= r64[63:56];
      @(posedge sys_clk);
      @(negedge sys_clk);
      st = exp_status(r64[59:0]);
      lk = (op == 2'h0) ? st[a] & st[b] : (op == 2'h1) ? st[a] | st[b] : st[a] ^ st[b];
      chk({29'h0, digital_out}, {29'h0, i[0] ? {3{lk}} : r64[58:56]});
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, {17'h0, lk, 3'h0, st});
      chk({29'h0, loads}, {29'h0, i[0] ? {3{lk}} : r64[58:56]});
    end
    give_verdict();
  end
endmodule : freq_offset_and_logic_link_tb
